// file: src/cfbs_fifo.sv
/*
  small flip-flop fifo with valid/ready on both sides.
  assumes: one clock, async active-low reset; depth a power of two.
*/
`timescale 1ns/1ps
`default_nettype none

module cfbs_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import cfbs_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // ========================================================
  // storage and pointers
  logic [WIDTH-1:0] mem_r   [DEPTH];  // entries
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;  // fill index
  logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;  // drain index
  logic [CW-1:0]    count_r,  count_nxt;   // occupancy
  logic             ready_nxt;
  logic             push, pop;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  // next pointers, count and ready
  always_comb begin
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = in_data;
      wr_ptr_nxt        = wr_ptr_r + AW'(1);
    end
    if (pop) begin
      rd_ptr_nxt = rd_ptr_r + AW'(1);
    end
    if (push && !pop) begin
      count_nxt = count_r + CW'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CW'(1);
    end
    ready_nxt = (count_nxt != CW'(DEPTH));  // honest full
  end

  // register state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mem_r    <= '{default: '0};
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      in_ready <= 1'b1;
    end else begin
      mem_r    <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      in_ready <= ready_nxt;
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge clock) disable iff (!rst_n)
    count_r <= CW'(DEPTH) && (in_ready == (count_r != CW'(DEPTH))))
    else $error("fifo occupancy or ready wrong");

endmodule

`default_nettype wire

// file: src/cfbs_msg_ram.sv
/*
  message buffer identifier words, 32 buffers of sid and eid words,
  kept apart from the register space.
  assumes: one writer per word per cycle, read index from the bus slave.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfbs_params.svh"

module cfbs_msg_ram (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        sid_we,
  input  wire logic        eid_we,
  input  wire logic [4:0]  widx,
  input  wire logic [12:0] wsid,
  input  wire logic [11:0] weid,
  input  wire logic [4:0]  ridx,
  output logic [12:0]      rsid,
  output logic [11:0]      reid
);
  import cfbs_pkg::*;

  // ========================================================
  // storage, one generate slice per buffer
  logic [12:0] sid_r [`CFBS_NUM_BUF];  // sid10..0, srr, ide
  logic [11:0] eid_r [`CFBS_NUM_BUF];  // eid17..6

  for (genvar g = 0; g < `CFBS_NUM_BUF; g++) begin : g_buf
    logic [12:0] sid_nxt;
    logic [11:0] eid_nxt;
    // next value of this buffer's words
    always_comb begin
      sid_nxt = sid_r[g];
      eid_nxt = eid_r[g];
      if (sid_we && widx == 5'(g)) begin
        sid_nxt = wsid;
      end
      if (eid_we && widx == 5'(g)) begin
        eid_nxt = weid;
      end
    end
    // register the words
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sid_r[g] <= 13'h0000;
        eid_r[g] <= 12'h000;
      end else begin
        sid_r[g] <= sid_nxt;
        eid_r[g] <= eid_nxt;
      end
    end
  end

  assign rsid = sid_r[ridx];
  assign reid = eid_r[ridx];

endmodule

`default_nettype wire

// file: src/cfbs_params.svh
/*
  constants of the filter steering and message buffer block: offsets,
  field positions, reset values and sizes.
  assumes: included by bare name from the design files.
*/
`ifndef CFBS_PARAMS_SVH
`define CFBS_PARAMS_SVH

// ==========================================================
// register offsets (byte address, low 12 bits)
`define CFBS_OFS_PTR_LO   12'h000
`define CFBS_OFS_PTR_HI   12'h004
`define CFBS_OFS_CTRL     12'h008
`define CFBS_OFS_STAT     12'h00C
`define CFBS_MSG_PAGE     4'h1

// ==========================================================
// field positions
`define CFBS_FLD_W        4
`define CFBS_SID_MSB      12
`define CFBS_SID_LSB      2
`define CFBS_SRR_BIT      1
`define CFBS_IDE_BIT      0
`define CFBS_EID_MSB      11
`define CFBS_CTRL_EN_BIT  0
`define CFBS_CTRL_CLR_BIT 1

// ==========================================================
// reset values and sizes
`define CFBS_PTR_RST      16'h0000
`define CFBS_CTRL_EN_RST  1'b1
`define CFBS_FILT_FIRST   4'h4
`define CFBS_FILT_LAST    4'hB
`define CFBS_NUM_BUF      32
`define CFBS_FIFO_DEPTH   4

`endif

// file: src/cfbs_pkg.sv
/*
  types of the filter steering and message buffer block.
  assumes: compiled before every other design file.
*/
package cfbs_pkg;

  // ========================================================
  // bus slave states, gray along idle -> read data -> idle
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_RDATA = 1'b1
  } cfbs_bus_st_t;

  // received message: filter(4) sid(11) srr ide eid17..6(12)
  typedef logic [28:0] cfbs_rx_word_t;

endpackage

// file: src/cfbs_top.sv
/*
  can receive steering and message buffer identifier words behind an
  ahb-lite slave. received messages pass a 4-word fifo, then filters
  4..11 steer each into the buffer named by their pointer field.
  assumes: ahb-lite master with single word transfers, one clock,
  filter matching done upstream.
*/
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
// Functional notes
// R1: filters 4-7 steer via pointer-low fields
// R2: filters 8-11 steer via pointer-high fields
// R3: sid word holds identifier in bits 12-2
// R4: sid bit 1 is srr
// R5: sid bit 0 is ide
// R6: eid word bits 11-0 hold eid17-6
// R7: buffers live apart from register space
// R8: unused identifier upper bits read zero
// R9: pointers are binary indices, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "cfbs_params.svh"

module cfbs_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [3:0]  rx_filter,
  input  wire logic [10:0] rx_sid,
  input  wire logic        rx_srr,
  input  wire logic        rx_ide,
  input  wire logic [11:0] rx_eid,
  output logic             rx_stored,
  output logic [3:0]       rx_stored_buffer
);
  import cfbs_pkg::*;

  // ========================================================
  // decode functions
  // filter index that has a pointer field here
  function automatic logic filter_steered(input logic [3:0] f);
    filter_steered = (f >= `CFBS_FILT_FIRST) && (f <= `CFBS_FILT_LAST);
  endfunction

  // pointer field selected by a filter index
  function automatic logic [3:0] steer_target(input logic [3:0]  f,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
    logic [15:0] w;
    w = f[3] ? hi : lo;
    steer_target = w[{f[1:0], 2'b00} +: `CFBS_FLD_W];
  endfunction

  // address falls in the message buffer page
  function automatic logic is_msg(input logic [11:0] a);
    is_msg = (a[11:8] == `CFBS_MSG_PAGE);
  endfunction

  // ========================================================
  // declarations
  cfbs_bus_st_t  st_r, st_nxt;          // bus slave state
  logic [11:0]   addr_r, addr_nxt;      // data-phase address
  logic          wr_r, wr_nxt;          // write data phase pending
  logic          rdy_nxt;               // next hreadyout
  logic [31:0]   rdata_nxt;             // next hrdata
  logic [31:0]   rd_value;              // decoded read value
  logic          acc;                   // address phase taken
  logic [15:0]   ptr_lo_r, ptr_lo_nxt;  // filter 4-7 pointers
  logic [15:0]   ptr_hi_r, ptr_hi_nxt;  // filter 8-11 pointers
  logic          en_r, en_nxt;          // steering enable
  logic          ptr_wr_seen_r;         // any pointer write yet
  logic [7:0]    st_cnt_r, st_cnt_nxt;  // stored messages
  logic [7:0]    dr_cnt_r, dr_cnt_nxt;  // dropped messages
  logic [3:0]    last_nxt;              // next stored buffer
  logic          stored_nxt;            // next store pulse
  cfbs_rx_word_t in_word, head;         // fifo words
  logic          head_valid, pop;       // fifo drain side
  logic          hit;                   // head is steered
  logic [3:0]    target;                // head's buffer
  logic          bus_msg_wr;            // bus owns the ram
  logic          clr;                   // counter clear strobe
  logic          sid_we, eid_we;        // ram write enables
  logic [4:0]    widx;                  // ram write index
  logic [12:0]   wsid, rsid;            // sid words
  logic [11:0]   weid, reid;            // eid words

  assign acc = hsel & htrans[1] & hready;

  // ========================================================
  // ahb-lite slave: writes zero wait, reads one wait state
  always_comb begin
    st_nxt    = st_r;
    addr_nxt  = addr_r;
    wr_nxt    = 1'b0;
    rdy_nxt   = hreadyout;
    rdata_nxt = hrdata;
    case (st_r)
      ST_IDLE: begin
        if (acc) begin
          addr_nxt = haddr[11:0];
          wr_nxt   = hwrite;
          if (!hwrite) begin  // read: hold hready low one cycle
            st_nxt  = ST_RDATA;
            rdy_nxt = 1'b0;
          end
        end
      end
      ST_RDATA: begin  // load read data, release hready
        rdata_nxt = rd_value;
        rdy_nxt   = 1'b1;
        st_nxt    = ST_IDLE;
      end
      default: begin
        st_nxt  = ST_IDLE;
        rdy_nxt = 1'b1;
      end
    endcase
  end

  // register bus state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= ST_IDLE;
      addr_r    <= 12'h000;
      wr_r      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      addr_r    <= addr_nxt;
      wr_r      <= wr_nxt;
      hreadyout <= rdy_nxt;
      hrdata    <= rdata_nxt;
      hresp     <= 1'b0;  // always okay
    end
  end

  // read decode; unmapped reads zero
  always_comb begin
    rd_value = 32'h0000_0000;
    if (is_msg(addr_r)) begin  // [R7]
      if (addr_r[2]) begin
        rd_value = {20'h00000, reid};  // [R6] [R8]
      end else begin
        rd_value = {19'h00000, rsid};  // [R3] [R8]
      end
    end else begin
      case (addr_r)
        `CFBS_OFS_PTR_LO: rd_value = {16'h0000, ptr_lo_r};
        `CFBS_OFS_PTR_HI: rd_value = {16'h0000, ptr_hi_r};
        `CFBS_OFS_CTRL:   rd_value = {31'h0000_0000, en_r};
        `CFBS_OFS_STAT:   rd_value = {8'h00, dr_cnt_r, st_cnt_r,
                                      4'h0, rx_stored_buffer};
        default:          rd_value = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================
  // control registers and counters
  assign clr = wr_r && addr_r == `CFBS_OFS_CTRL && hwdata[`CFBS_CTRL_CLR_BIT];

  always_comb begin
    ptr_lo_nxt = ptr_lo_r;
    ptr_hi_nxt = ptr_hi_r;
    en_nxt     = en_r;
    if (wr_r && addr_r == `CFBS_OFS_PTR_LO) begin
      ptr_lo_nxt = hwdata[15:0];  // [R1]
    end
    if (wr_r && addr_r == `CFBS_OFS_PTR_HI) begin
      ptr_hi_nxt = hwdata[15:0];  // [R2]
    end
    if (wr_r && addr_r == `CFBS_OFS_CTRL) begin
      en_nxt = hwdata[`CFBS_CTRL_EN_BIT];
    end
    // an event in the clear cycle still counts
    st_cnt_nxt = clr ? 8'h00 : st_cnt_r;
    dr_cnt_nxt = clr ? 8'h00 : dr_cnt_r;
    if (pop && hit) begin
      st_cnt_nxt = st_cnt_nxt + 8'h01;
    end
    if (pop && !hit) begin
      dr_cnt_nxt = dr_cnt_nxt + 8'h01;
    end
    stored_nxt = pop && hit;
    last_nxt   = (pop && hit) ? target : rx_stored_buffer;
  end

  // register control state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_lo_r         <= `CFBS_PTR_RST;  // [R9]
      ptr_hi_r         <= `CFBS_PTR_RST;  // [R9]
      en_r             <= `CFBS_CTRL_EN_RST;
      ptr_wr_seen_r    <= 1'b0;
      st_cnt_r         <= 8'h00;
      dr_cnt_r         <= 8'h00;
      rx_stored        <= 1'b0;
      rx_stored_buffer <= 4'h0;
    end else begin
      ptr_lo_r         <= ptr_lo_nxt;
      ptr_hi_r         <= ptr_hi_nxt;
      en_r             <= en_nxt;
      ptr_wr_seen_r    <= ptr_wr_seen_r | (wr_r && !is_msg(addr_r) &&
                          addr_r[11:3] == 9'h000);
      st_cnt_r         <= st_cnt_nxt;
      dr_cnt_r         <= dr_cnt_nxt;
      rx_stored        <= stored_nxt;
      rx_stored_buffer <= last_nxt;
    end
  end

  // ========================================================
  // receive path: fifo, then steering into the buffers
  assign in_word = {rx_filter, rx_sid, rx_srr, rx_ide, rx_eid};

  cfbs_fifo #(
    .WIDTH ($bits(cfbs_rx_word_t)),
    .DEPTH (`CFBS_FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (in_word),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head)
  );

  assign hit        = filter_steered(head[28:25]);
  assign target     = steer_target(head[28:25], ptr_lo_r, ptr_hi_r);  // [R1] [R2] [R9]
  assign bus_msg_wr = wr_r && is_msg(addr_r);
  // a bus write to the buffers, or steering off, stalls the drain
  assign pop        = head_valid && en_r && !bus_msg_wr;

  // one write port: bus first, else the steered message
  always_comb begin
    if (bus_msg_wr) begin
      sid_we = !addr_r[2];
      eid_we = addr_r[2];
      widx   = addr_r[7:3];
      wsid   = hwdata[`CFBS_SID_MSB:0];
      weid   = hwdata[`CFBS_EID_MSB:0];
    end else begin
      sid_we = pop && hit;
      eid_we = pop && hit;
      widx   = {1'b0, target};  // [R9]
      wsid   = head[24:12];     // [R3] [R4] [R5]
      weid   = head[11:0];      // [R6]
    end
  end

  cfbs_msg_ram u_ram (
    .clock  (clock),
    .rst_n  (rst_n),
    .sid_we (sid_we),
    .eid_we (eid_we),
    .widx   (widx),
    .wsid   (wsid),
    .weid   (weid),
    .ridx   (addr_r[7:3]),
    .rsid   (rsid),
    .reid   (reid)
  );

  // ========================================================
  // assertions
  sequence s_pop_lo;
    pop && head[28:25] >= 4'h4 && head[28:25] <= 4'h7;
  endsequence

  sequence s_pop_hi;
    pop && head[28:25] >= 4'h8 && head[28:25] <= 4'hB;
  endsequence

  sequence s_read_taken;
    st_r == ST_IDLE && acc && !hwrite;
  endsequence

  AST_STEER_LO: assert property (@(posedge clock) disable iff (!rst_n)  // [R1]
    s_pop_lo |=> rx_stored &&
      rx_stored_buffer == $past(ptr_lo_r[{head[26:25], 2'b00} +: 4]))
    else $error("filter 4-7 steered to wrong buffer");

  AST_STEER_HI: assert property (@(posedge clock) disable iff (!rst_n)  // [R2]
    s_pop_hi |=> rx_stored &&
      rx_stored_buffer == $past(ptr_hi_r[{head[26:25], 2'b00} +: 4]))
    else $error("filter 8-11 steered to wrong buffer");

  AST_SID_FIELD: assert property (@(posedge clock) disable iff (!rst_n)  // [R3]
    (pop && hit) |-> sid_we && wsid[12:2] == head[24:14])
    else $error("standard identifier not in bits 12-2");

  AST_SRR_BIT: assert property (@(posedge clock) disable iff (!rst_n)  // [R4]
    (pop && hit) |-> wsid[1] == head[13])
    else $error("srr not in bit 1");

  AST_IDE_BIT: assert property (@(posedge clock) disable iff (!rst_n)  // [R5]
    (pop && hit) |-> wsid[0] == head[12])
    else $error("ide not in bit 0");

  AST_EID_FIELD: assert property (@(posedge clock) disable iff (!rst_n)  // [R6]
    (pop && hit) |-> eid_we && weid == head[11:0] && widx == {1'b0, target})
    else $error("extended identifier word wrong");

  AST_DMA_APART: assert property (@(posedge clock) disable iff (!rst_n)  // [R7]
    (wr_r && !is_msg(addr_r)) |-> !(sid_we && !pop) && !(eid_we && !pop))
    else $error("register write reached the buffers");

  AST_UPPER_ZERO: assert property (@(posedge clock) disable iff (!rst_n)  // [R8]
    (s_read_taken ##1 is_msg(addr_r)) |=>
      hreadyout && (addr_r[2] ? hrdata[31:12] == 20'h00000
                              : hrdata[31:13] == 19'h00000))
    else $error("identifier upper bits not zero");

  AST_PTR_RESET: assert property (@(posedge clock) disable iff (!rst_n)  // [R9]
    !ptr_wr_seen_r |-> ptr_lo_r == 16'h0000 && ptr_hi_r == 16'h0000)
    else $error("pointer not zero before first write");

  AST_READ_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
    s_read_taken |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule

`default_nettype wire

// file: test/cfbs_rx_source.sv
/*
  model of the far side: other bus nodes offering received messages
  on the rx stream after filter matching.
  assumes: sampled on the rising clock edge, rx_ready from the block.
*/
`timescale 1ns/1ps
`default_nettype none

module cfbs_rx_source (
  input  wire logic        clock,
  input  wire logic        rx_ready,
  output var  logic        rx_valid,
  output var  logic [3:0]  rx_filter,
  output var  logic [10:0] rx_sid,
  output var  logic        rx_srr,
  output var  logic        rx_ide,
  output var  logic [11:0] rx_eid
);
  // ==========================================================
  // idle values at time zero
  initial begin
    rx_valid  = 1'b0;
    rx_filter = 4'h0;
    rx_sid    = 11'h000;
    rx_srr    = 1'b0;
    rx_ide    = 1'b0;
    rx_eid    = 12'h000;
  end

  // ==========================================================
  // offer one message, hold until taken, then scramble the lines
  task automatic send(input logic [3:0] f, input logic [10:0] s,
                      input logic r, input logic i, input logic [11:0] e);
    @(posedge clock);
    rx_valid  <= 1'b1;
    rx_filter <= f;
    rx_sid    <= s;
    rx_srr    <= r;
    rx_ide    <= i;
    rx_eid    <= e;
    @(posedge clock);
    // stall while the fifo is full
    while (rx_ready !== 1'b1) begin
      @(posedge clock);
    end
    // released lines no longer show the last value
    rx_valid  <= 1'b0;
    rx_filter <= ~f;
    rx_sid    <= ~s;
    rx_srr    <= ~r;
    rx_ide    <= ~i;
    rx_eid    <= ~e;
  endtask
endmodule

`default_nettype wire

// file: test/test_can_filter_buffer_steering.sv
/*
  self-checking bench: ahb-lite master tasks, rx source model, one task
  per scenario.
  assumes: cfbs_top with one ahb slave, hready tied to hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfbs_params.svh"

module test_can_filter_buffer_steering;
  // ==========================================================
  // signals
  logic        clock = 1'b0;     // 200 MHz
  logic        rst_n = 1'b0;     // async, active low
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0, hreadyout, hresp;
  logic [2:0]  hsize = 3'h2;     // always a word
  logic        rx_valid, rx_ready, rx_srr, rx_ide, rx_stored;
  logic [3:0]  rx_filter, rx_stored_buffer;
  logic [10:0] rx_sid;
  logic [11:0] rx_eid;
  int          n_mismatch = 0, samples_checked = 0, n_store = 0;

  always #2.5 clock = ~clock;

  cfbs_top u_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_filter(rx_filter),
    .rx_sid(rx_sid), .rx_srr(rx_srr), .rx_ide(rx_ide), .rx_eid(rx_eid),
    .rx_stored(rx_stored), .rx_stored_buffer(rx_stored_buffer));

  cfbs_rx_source u_src (.clock(clock), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_filter(rx_filter), .rx_sid(rx_sid), .rx_srr(rx_srr), .rx_ide(rx_ide),
    .rx_eid(rx_eid));

  // counts store pulses seen at each edge
  always @(posedge clock) begin
    if (rx_stored === 1'b1) begin
      n_store <= n_store + 1;
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // address phase, held until hready seen high
  task automatic ahb_addr(input logic [31:0] a, input logic w);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
  endtask

  task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
    ahb_addr(a, 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
  endtask

  task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
    ahb_addr(a, 1'b0);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    d = hrdata;
  endtask

  // bounded wait for a store count
  task automatic wait_store(input int target);
    int k;
    k = 0;
    while (n_store < target && k < 60) begin
      @(posedge clock);
      k++;
    end
    check(32'(n_store), 32'(target));
  endtask

  // sends one message for filter f, checks buffer b and its words
  task automatic steer_one(input logic [3:0] f, input logic [3:0] b);
    logic [31:0] d;
    int          base;
    base = n_store;
    u_src.send(f, 11'h7A0 + 11'(f), f[0], f[1], 12'hC30 + 12'(f));
    wait_store(base + 1);
    check({28'h0, rx_stored_buffer}, {28'h0, b});
    ahb_read(32'h100 + 32'(b) * 8, d);
    check(d, {19'h0, 11'h7A0 + 11'(f), f[0], f[1]});
    ahb_read(32'h104 + 32'(b) * 8, d);
    check(d, {20'h0, 12'hC30 + 12'(f)});
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset;
    logic [31:0] d;
    ahb_read({20'h0, `CFBS_OFS_PTR_LO}, d);
    check(d, 32'h0000_0000);
    ahb_read({20'h0, `CFBS_OFS_PTR_HI}, d);
    check(d, 32'h0000_0000);
    ahb_read(32'h0000_0040, d);
    check(d, 32'h0000_0000);
    steer_one(4'h4, 4'h0);
    steer_one(4'hB, 4'h0);
    $display("test reset done");
  endtask

  task automatic test_steer;
    logic [31:0] d;
    logic [31:0] lo, hi;
    lo = 32'hABCD_FC96;
    hi = 32'h5A5A_1E82;
    ahb_write({20'h0, `CFBS_OFS_PTR_LO}, lo);
    ahb_write({20'h0, `CFBS_OFS_PTR_HI}, hi);
    ahb_read({20'h0, `CFBS_OFS_PTR_LO}, d);
    check(d, {16'h0, lo[15:0]});
    ahb_read({20'h0, `CFBS_OFS_PTR_HI}, d);
    check(d, {16'h0, hi[15:0]});
    for (int f = 4; f < 8; f++) begin
      steer_one(4'(f), lo[(f-4)*4 +: 4]);
    end
    for (int f = 8; f < 12; f++) begin
      steer_one(4'(f), hi[(f-8)*4 +: 4]);
    end
    $display("test steer done");
  endtask

  task automatic test_upper_zero;
    logic [31:0] d;
    ahb_write(32'h0000_01A0, 32'hFFFF_FFFF);
    ahb_write(32'h0000_01A4, 32'hFFFF_FFFF);
    ahb_read(32'h0000_01A0, d);
    check(d, 32'h0000_1FFF);
    ahb_read(32'h0000_01A4, d);
    check(d, 32'h0000_0FFF);
    $display("test upper bits done");
  endtask

  task automatic test_drop_and_fill;
    int base;
    base = n_store;
    u_src.send(4'h2, 11'h123, 1'b0, 1'b0, 12'h456);
    u_src.send(4'hC, 11'h321, 1'b1, 1'b1, 12'h654);
    repeat (10) @(posedge clock);
    check(32'(n_store), 32'(base));
    ahb_write({20'h0, `CFBS_OFS_CTRL}, 32'h0000_0000);
    for (int k = 0; k < `CFBS_FIFO_DEPTH; k++) begin
      u_src.send(4'h5, 11'h0AA, 1'b0, 1'b1, 12'h0F0);
    end
    @(posedge clock);
    check({31'h0, rx_ready}, 32'h0);
    fork
      u_src.send(4'h9, 11'h555, 1'b1, 1'b0, 12'hABC);
      begin
        repeat (4) @(posedge clock);
        check(32'(n_store), 32'(base));
        ahb_write({20'h0, `CFBS_OFS_CTRL}, 32'h0000_0001);
      end
    join
    wait_store(base + 5);
    check({28'h0, rx_stored_buffer}, 32'h0000_0008);
    $display("test fifo done");
  endtask

  // status counters after the run so far, then a clear through control
  task automatic test_status;
    logic [31:0] d;
    ahb_read({20'h0, `CFBS_OFS_STAT}, d);
    check(d, 32'h0002_0F08);
    check({31'h0, hresp}, 32'h0);
    ahb_write({20'h0, `CFBS_OFS_CTRL}, 32'h0000_0003);
    ahb_read({20'h0, `CFBS_OFS_STAT}, d);
    check(d, 32'h0000_0008);
    ahb_read({20'h0, `CFBS_OFS_CTRL}, d);
    check(d, 32'h0000_0001);
    $display("test status done");
  endtask

  // ==========================================================
  // closing
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #50000ns;
    n_mismatch++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    test_reset();
    test_steer();
    test_upper_zero();
    test_drop_and_fill();
    test_status();
    stop_test();
  end
endmodule

`default_nettype wire
